// ===== verilog/rscl_pkg.sv
// Package: register map, field positions, reset values and state codes of the strap loader
package rscl_pkg;

    localparam int          ADDR_W          = 6;
    localparam int          DATA_W          = 32;
    localparam int          REG_W           = 16;

    // Register byte offsets
    localparam logic [5:0]  OFF_BASIC_CTRL  = 6'h00;
    localparam logic [5:0]  OFF_MAC_IFACE   = 6'h04;
    localparam logic [5:0]  OFF_XOVER_CTRL  = 6'h08;
    localparam logic [5:0]  OFF_MDI_FORCE   = 6'h0c;
    localparam logic [5:0]  OFF_CLK_DELAY   = 6'h10;
    localparam logic [5:0]  OFF_AUX_CLOCK   = 6'h14;
    localparam logic [5:0]  OFF_POWER_CTRL  = 6'h18;
    localparam logic [5:0]  OFF_TEN_TE      = 6'h1c;
    localparam logic [5:0]  OFF_STATUS      = 6'h20;

    // Register indices returned by the decoder
    localparam logic [3:0]  IDX_BASIC       = 4'h0;
    localparam logic [3:0]  IDX_MACIF       = 4'h1;
    localparam logic [3:0]  IDX_XOVER       = 4'h2;
    localparam logic [3:0]  IDX_MDI         = 4'h3;
    localparam logic [3:0]  IDX_DELAY       = 4'h4;
    localparam logic [3:0]  IDX_AUX         = 4'h5;
    localparam logic [3:0]  IDX_POWER       = 4'h6;
    localparam logic [3:0]  IDX_TENTE       = 4'h7;
    localparam logic [3:0]  IDX_STATUS      = 4'h8;
    localparam logic [3:0]  IDX_NONE        = 4'hf;

    // Field positions
    localparam int          BIT_SPEED_LSB   = 13;
    localparam int          BIT_AN_EN       = 12;
    localparam int          BIT_DUPLEX      = 8;
    localparam int          BIT_SPEED_MSB   = 6;
    localparam int          POS_MACIF       = 11;
    localparam int          BIT_XOVER_FDIS  = 7;
    localparam int          BIT_AMDIX_DIS   = 5;
    localparam int          BIT_POL_DIS     = 4;
    localparam int          POS_MDI_FORCE   = 2;
    localparam int          POS_RX_DELAY    = 4;
    localparam int          POS_TX_DELAY    = 0;
    localparam int          BIT_AUX_EN      = 15;
    localparam int          POS_AUX_FREQ    = 13;
    localparam int          BIT_LINK_PD     = 6;
    localparam int          BIT_TEN_TE      = 15;

    // Writable bits of each register
    localparam logic [15:0] WMASK_BASIC     = 16'h3140;
    localparam logic [15:0] WMASK_MACIF     = 16'h1800;
    localparam logic [15:0] WMASK_XOVER     = 16'h00b0;
    localparam logic [15:0] WMASK_MDI       = 16'h000c;
    localparam logic [15:0] WMASK_DELAY     = 16'h0077;
    localparam logic [15:0] WMASK_AUX       = 16'he000;
    localparam logic [15:0] WMASK_POWER     = 16'h0040;
    localparam logic [15:0] WMASK_TENTE     = 16'h8000;

    // Values after reset, before the straps are applied
    localparam logic [15:0] RST_XOVER       = 16'h0080;
    localparam logic [15:0] RST_MDI         = 16'h0000;
    localparam logic [15:0] RST_AUX_EN      = 16'h8000;
    localparam logic [15:0] RST_TENTE       = 16'h0000;
    localparam logic [2:0]  RST_DELAY_MGD   = 3'h0;

    // MAC interface codes
    localparam logic [1:0]  MACIF_MII       = 2'h0;
    localparam logic [1:0]  MACIF_RMII      = 2'h1;
    localparam logic [1:0]  MACIF_RGMII     = 2'h2;

    // Manual crossover codes
    localparam logic [1:0]  MDI_FORCE_MDI   = 2'h2;
    localparam logic [1:0]  MDI_FORCE_MDIX  = 2'h3;

    localparam logic [1:0]  RESP_OKAY       = 2'h0;
    localparam logic [1:0]  RESP_SLVERR     = 2'h2;

    typedef enum logic [1:0] {
        ST_CAPTURE = 2'b01,
        ST_RUN     = 2'b10
    } rscl_state_t;

endpackage : rscl_pkg

// ===== verilog/rscl_strap_loader.sv
// Strap capture, derived register defaults, media-side controls and AXI4-Lite register slave
//
// How it works
// R1: Mode strap high at reset release selects unmanaged mode using straps as defaults.
// R2: Mode strap low selects managed mode; five straps give PHY address bits 0-4.
// R3: Board logic must not drive strap pins while reset is held.
// R4: Unmanaged straps set speed, autoneg, duplex, MAC interface, crossover, clock delay defaults; here crossover is not strap-loaded and keeps RST_XOVER.
// R5: Unmanaged mode sets the link power-down enable bit to 1 by default.
// R6: Delay straps load rx and tx delay: 00->000, 01->010, 10->100, 11->110.
// R7: Link straps: 0x autoneg all modes, 10 forced 100 half, 11 forced 10 half.
// R8: Unmanaged interface strap 0 selects RGMII, 1 selects RMII.
// R9: With RMII strapped, board must pick a forced link advertisement pattern.
// R10: No checking or correction of inconsistent strap or register settings.
// R11: Unmanaged address straps set address bits 0 and 1, upper three bits zero.
// R12: Narrow interface strap low selects RGMII, high selects MII.
// R13: Unmanaged RMII strap overrides the narrow interface strap.
// R14: Frequency straps load aux clock frequency default: 00 25, 01 50, 10 125 MHz.
// R15: Aux clock frequency field stays writable from software.
// R16: Clearing autoneg enable takes speed and duplex from the control bits.
// R17: Partner without autonegotiation gets speed chosen by parallel detection.
// R18: Auto crossover and polarity correction enabled after reset, disabled by two bits.
// R19: Forced 10/100 link runs auto crossover when forced-mode disable bit cleared.
// R20: Manual crossover field: 10 MDI, 11 MDI-X, 00 automatic by control bits.
// R21: MDI transmits on channel A, receives on B; MDI-X swaps them.
// R22: Reduced-amplitude ten-megabit bit set selects 10BASE-Te.
// R23: Low power idle is allowed only in 100BASE-TX operation.
// R24: Straps held in flops from reset release until the next reset.
`timescale 1ns/100ps

module rscl_strap_loader
    import rscl_pkg::*;
(
    input  wire logic                          aclk,
    input  wire logic                          aresetn,
    // Strap pins
    input  wire logic                          mode_select_strap,
    input  wire logic                          delay_a_strap,
    input  wire logic                          delay_b_strap,
    input  wire logic                          link_c_strap,
    input  wire logic                          link_d_strap,
    input  wire logic                          iface_e_strap,
    input  wire logic                          narrow_iface_select_strap,
    input  wire logic                          addr_bit0_strap,
    input  wire logic                          addr_bit1_strap,
    input  wire logic                          freq_bit0_strap,
    input  wire logic                          freq_bit1_strap,
    // Media-side status from link logic
    input  wire logic                          partner_autoneg_able,
    input  wire logic                          partner_speed_100,
    input  wire logic                          mdix_detected,
    input  wire logic                          lpi_request,
    // AXI4-Lite slave
    input  wire logic [rscl_pkg::ADDR_W-1:0]   s_axi_awaddr,
    input  wire logic                          s_axi_awvalid,
    output logic                               s_axi_awready,
    input  wire logic [rscl_pkg::DATA_W-1:0]   s_axi_wdata,
    input  wire logic [3:0]                    s_axi_wstrb,
    input  wire logic                          s_axi_wvalid,
    output logic                               s_axi_wready,
    output logic [1:0]                         s_axi_bresp,
    output logic                               s_axi_bvalid,
    input  wire logic                          s_axi_bready,
    input  wire logic [rscl_pkg::ADDR_W-1:0]   s_axi_araddr,
    input  wire logic                          s_axi_arvalid,
    output logic                               s_axi_arready,
    output logic [rscl_pkg::DATA_W-1:0]        s_axi_rdata,
    output logic [1:0]                         s_axi_rresp,
    output logic                               s_axi_rvalid,
    input  wire logic                          s_axi_rready,
    // Configuration outputs
    output logic                               config_valid,
    output logic                               managed_mode,
    output logic [4:0]                         phy_address,
    output logic [1:0]                         mac_iface_mode,
    output logic [2:0]                         rx_clk_delay,
    output logic [2:0]                         tx_clk_delay,
    output logic                               link_power_down_en,
    output logic                               aux_clock_enable,
    output logic [1:0]                         aux_clock_freq,
    output logic                               an_enable,
    output logic                               speed_100,
    output logic                               full_duplex,
    output logic                               polarity_correct_en,
    output logic                               mdi_x,
    output logic                               tx_on_channel_b,
    output logic                               rx_on_channel_b,
    output logic                               ten_te_enable,
    output logic                               lpi_allowed
);

    ////////////////////////////////////////////////////////////////////////////////
    // Helpers

    function automatic logic [3:0] reg_index(input logic [ADDR_W-1:0] addr);
        if (addr == OFF_BASIC_CTRL) begin
            return IDX_BASIC;
        end else if (addr == OFF_MAC_IFACE) begin
            return IDX_MACIF;
        end else if (addr == OFF_XOVER_CTRL) begin
            return IDX_XOVER;
        end else if (addr == OFF_MDI_FORCE) begin
            return IDX_MDI;
        end else if (addr == OFF_CLK_DELAY) begin
            return IDX_DELAY;
        end else if (addr == OFF_AUX_CLOCK) begin
            return IDX_AUX;
        end else if (addr == OFF_POWER_CTRL) begin
            return IDX_POWER;
        end else if (addr == OFF_TEN_TE) begin
            return IDX_TENTE;
        end else if (addr == OFF_STATUS) begin
            return IDX_STATUS;
        end else begin
            return IDX_NONE;
        end
    endfunction : reg_index

    function automatic logic [REG_W-1:0] merge(
        input logic [REG_W-1:0] old,
        input logic [DATA_W-1:0] wdata,
        input logic [3:0] wstrb,
        input logic [REG_W-1:0] mask
    );
        logic [REG_W-1:0] lanes;
        lanes = {{8{wstrb[1]}}, {8{wstrb[0]}}} & mask;
        return (old & ~lanes) | (wdata[REG_W-1:0] & lanes);
    endfunction : merge

    ////////////////////////////////////////////////////////////////////////////////
    // Strap synchronisers: pins are outside the clock domain

    localparam int NSTRAP = 11;

    logic [NSTRAP-1:0] strap_pins;
    logic [NSTRAP-1:0] strap_meta;
    logic [NSTRAP-1:0] strap_sync;
    logic [NSTRAP-1:0] strap_hold;

    assign strap_pins = {freq_bit1_strap, freq_bit0_strap, addr_bit1_strap, addr_bit0_strap,
                         narrow_iface_select_strap, iface_e_strap, link_d_strap, link_c_strap,
                         delay_b_strap, delay_a_strap, mode_select_strap};

    // No reset here, so the pulled levels are already settled at release
    always_ff @(posedge aclk) begin
        strap_meta <= strap_pins;
        strap_sync <= strap_meta;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Capture sequence

    rscl_state_t state;
    rscl_state_t next_state;
    logic        capture;

    assign capture    = (state == ST_CAPTURE);
    assign next_state = capture ? ST_RUN : state;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state <= ST_CAPTURE;
        end else begin
            state <= next_state;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            strap_hold <= '0;
        end else if (capture) begin
            strap_hold <= strap_sync; // R24
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Strap-derived defaults, taken from the live synchronised levels at capture

    logic        s_unmgd;
    logic        s_a;
    logic        s_b;
    logic        s_c;
    logic        s_d;
    logic        s_e;
    logic        s_narrow;
    logic [1:0]  s_freq;
    logic [2:0]  def_delay;
    logic [1:0]  def_macif;
    logic [15:0] def_basic;

    assign s_unmgd  = strap_sync[0];
    assign s_a      = strap_sync[1];
    assign s_b      = strap_sync[2];
    assign s_c      = strap_sync[3];
    assign s_d      = strap_sync[4];
    assign s_e      = strap_sync[5];
    assign s_narrow = strap_sync[6];
    assign s_freq   = strap_sync[10:9];

    assign def_delay = s_unmgd ? {s_a, s_b, 1'b0} : RST_DELAY_MGD; // R6 R4
    // Combinations are applied as strapped, never corrected
    assign def_macif = (s_unmgd && s_e) ? MACIF_RMII :              // R8 R13 R10
                       s_narrow         ? MACIF_MII  : MACIF_RGMII; // R12
    // Managed mode and strap 0x both give autoneg with the speed 100 and full duplex bits set
    always_comb begin
        def_basic = '0;
        def_basic[BIT_AN_EN]     = !(s_unmgd && s_c);               // R7 R4
        def_basic[BIT_SPEED_LSB] = !(s_unmgd && s_c && s_d);        // R7
        def_basic[BIT_DUPLEX]    = !(s_unmgd && s_c);               // R7
    end

    ////////////////////////////////////////////////////////////////////////////////
    // AXI4-Lite handshakes

    logic       wr_fire;
    logic       rd_fire;
    logic [3:0] wr_idx;
    logic [3:0] rd_idx;

    // Bus stalls until the straps have been applied
    assign s_axi_awready = !capture && s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
    assign s_axi_wready  = s_axi_awready;
    assign s_axi_arready = !capture && !s_axi_rvalid;
    assign wr_fire       = s_axi_awready;
    assign rd_fire       = s_axi_arready && s_axi_arvalid;
    assign wr_idx        = reg_index(s_axi_awaddr);
    assign rd_idx        = reg_index(s_axi_araddr);

    ////////////////////////////////////////////////////////////////////////////////
    // Control registers

    logic [15:0] basic_reg;
    logic [15:0] macif_reg;
    logic [15:0] xover_reg;
    logic [15:0] mdi_reg;
    logic [15:0] delay_reg;
    logic [15:0] aux_reg;
    logic [15:0] power_reg;
    logic [15:0] tente_reg;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            basic_reg <= '0;
            macif_reg <= '0;
            xover_reg <= RST_XOVER; // R18
            mdi_reg   <= RST_MDI;
            delay_reg <= '0;
            aux_reg   <= RST_AUX_EN;
            power_reg <= '0;
            tente_reg <= RST_TENTE;
        end else if (capture) begin
            basic_reg <= def_basic; // R4
            macif_reg <= 16'({def_macif, 11'h000}); // R4
            delay_reg <= 16'({def_delay, 1'b0, def_delay}); // R6
            aux_reg   <= RST_AUX_EN | 16'({s_freq, 13'h0000}); // R14
            power_reg <= 16'({s_unmgd, 6'h00}); // R5
        end else if (wr_fire) begin
            if (wr_idx == IDX_BASIC) begin
                basic_reg <= merge(basic_reg, s_axi_wdata, s_axi_wstrb, WMASK_BASIC);
            end
            if (wr_idx == IDX_MACIF) begin
                macif_reg <= merge(macif_reg, s_axi_wdata, s_axi_wstrb, WMASK_MACIF);
            end
            if (wr_idx == IDX_XOVER) begin
                xover_reg <= merge(xover_reg, s_axi_wdata, s_axi_wstrb, WMASK_XOVER);
            end
            if (wr_idx == IDX_MDI) begin
                mdi_reg <= merge(mdi_reg, s_axi_wdata, s_axi_wstrb, WMASK_MDI);
            end
            if (wr_idx == IDX_DELAY) begin
                delay_reg <= merge(delay_reg, s_axi_wdata, s_axi_wstrb, WMASK_DELAY);
            end
            if (wr_idx == IDX_AUX) begin
                aux_reg <= merge(aux_reg, s_axi_wdata, s_axi_wstrb, WMASK_AUX); // R15
            end
            if (wr_idx == IDX_POWER) begin
                power_reg <= merge(power_reg, s_axi_wdata, s_axi_wstrb, WMASK_POWER);
            end
            if (wr_idx == IDX_TENTE) begin
                tente_reg <= merge(tente_reg, s_axi_wdata, s_axi_wstrb, WMASK_TENTE);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Link resolution

    logic       an_bit;
    logic       auto_xover;
    logic [1:0] mdi_force;
    logic       next_mdi_x;
    logic       next_speed_100;
    logic       next_full_duplex;

    assign an_bit     = basic_reg[BIT_AN_EN];
    assign mdi_force  = mdi_reg[POS_MDI_FORCE +: 2];
    // Forced links keep a fixed wiring unless the forced-mode disable bit is cleared
    assign auto_xover = !xover_reg[BIT_AMDIX_DIS] &&
                        (an_bit || !xover_reg[BIT_XOVER_FDIS]); // R18 R19
    assign next_mdi_x = (mdi_force == MDI_FORCE_MDI)  ? 1'b0 :  // R20
                        (mdi_force == MDI_FORCE_MDIX) ? 1'b1 :  // R20
                        (auto_xover && mdix_detected);          // R20
    // With autoneg off the control bits set speed and duplex
    assign next_speed_100   = !an_bit ? (basic_reg[BIT_SPEED_LSB] && !basic_reg[BIT_SPEED_MSB]) :
                              !partner_autoneg_able ? partner_speed_100 : // R17
                              basic_reg[BIT_SPEED_LSB]; // R16
    assign next_full_duplex = (an_bit && !partner_autoneg_able) ? 1'b0 :
                              basic_reg[BIT_DUPLEX]; // R16

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            speed_100       <= 1'b0;
            full_duplex     <= 1'b0;
            mdi_x           <= 1'b0;
            tx_on_channel_b <= 1'b0;
            rx_on_channel_b <= 1'b1;
            lpi_allowed     <= 1'b0;
        end else begin
            speed_100       <= next_speed_100;
            full_duplex     <= next_full_duplex;
            mdi_x           <= next_mdi_x;
            tx_on_channel_b <= next_mdi_x; // R21
            rx_on_channel_b <= !next_mdi_x; // R21
            lpi_allowed     <= lpi_request && next_speed_100 && !capture; // R23
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Register-driven outputs

    assign config_valid        = !capture;
    assign managed_mode        = !strap_hold[0]; // R1 R2
    assign phy_address         = managed_mode ? strap_hold[5:1]            // R2
                                              : {3'b000, strap_hold[8:7]}; // R11
    assign mac_iface_mode      = macif_reg[POS_MACIF +: 2];
    assign rx_clk_delay        = delay_reg[POS_RX_DELAY +: 3];
    assign tx_clk_delay        = delay_reg[POS_TX_DELAY +: 3];
    assign link_power_down_en  = power_reg[BIT_LINK_PD];
    assign aux_clock_enable    = aux_reg[BIT_AUX_EN];
    assign aux_clock_freq      = aux_reg[POS_AUX_FREQ +: 2];
    assign an_enable           = an_bit;
    assign polarity_correct_en = !xover_reg[BIT_POL_DIS]; // R18
    assign ten_te_enable       = tente_reg[BIT_TEN_TE]; // R22

    ////////////////////////////////////////////////////////////////////////////////
    // Read path

    logic [15:0] status_word;
    logic [15:0] rd_word;

    assign status_word = {4'h0, mdi_x, speed_100, full_duplex, managed_mode,
                          3'b000, phy_address};

    assign rd_word = (rd_idx == IDX_BASIC)  ? basic_reg :
                     (rd_idx == IDX_MACIF)  ? macif_reg :
                     (rd_idx == IDX_XOVER)  ? xover_reg :
                     (rd_idx == IDX_MDI)    ? mdi_reg   :
                     (rd_idx == IDX_DELAY)  ? delay_reg :
                     (rd_idx == IDX_AUX)    ? aux_reg   :
                     (rd_idx == IDX_POWER)  ? power_reg :
                     (rd_idx == IDX_TENTE)  ? tente_reg :
                     (rd_idx == IDX_STATUS) ? status_word : 16'h0000;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= RESP_OKAY;
        end else if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (wr_idx == IDX_NONE || wr_idx == IDX_STATUS) ? RESP_SLVERR
                                                                          : RESP_OKAY;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= '0;
            s_axi_rresp  <= RESP_OKAY;
        end else if (rd_fire) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= {16'h0000, rd_word};
            s_axi_rresp  <= (rd_idx == IDX_NONE) ? RESP_SLVERR : RESP_OKAY;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

endmodule : rscl_strap_loader

// ===== tb/rscl_props.sv
// Checker: strap capture, crossover and write-response properties
`timescale 1ns/100ps
module rscl_props (
    input wire logic       aclk,
    input wire logic       aresetn,
    input wire logic       mode_select_strap,
    input wire logic       addr_bit0_strap,
    input wire logic       addr_bit1_strap,
    input wire logic       freq_bit0_strap,
    input wire logic       freq_bit1_strap,
    input wire logic       s_axi_awvalid,
    input wire logic       s_axi_awready,
    input wire logic       s_axi_wvalid,
    input wire logic       s_axi_wready,
    input wire logic       s_axi_bvalid,
    input wire logic       config_valid,
    input wire logic       managed_mode,
    input wire logic [4:0] phy_address,
    input wire logic [1:0] aux_clock_freq,
    input wire logic       mdi_x,
    input wire logic       tx_on_channel_b,
    input wire logic       rx_on_channel_b
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence s_capture; $rose(config_valid); endsequence
    sequence s_wr_take; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    a_mode_capture: assert property (s_capture |-> managed_mode == !mode_select_strap)
        else $error("mode flag differs from strap");
    a_addr_upper: assert property (!managed_mode |-> phy_address[4:2] == 3'h0)
        else $error("upper address bits not zero");
    a_addr_low: assert property (s_capture ##0 !managed_mode |->
        phy_address[1:0] == {addr_bit1_strap, addr_bit0_strap})
        else $error("address bits differ from straps");
    a_freq_load: assert property (s_capture |->
        aux_clock_freq == {freq_bit1_strap, freq_bit0_strap})
        else $error("clock frequency differs from straps");
    // Straps are ignored after capture, so pin noise must never move these
    a_addr_held: assert property (config_valid ##1 config_valid |-> $stable(phy_address))
        else $error("address moved after capture");
    a_mode_held: assert property (config_valid ##1 config_valid |-> $stable(managed_mode))
        else $error("mode moved after capture");
    a_pair_swap: assert property (tx_on_channel_b == mdi_x && rx_on_channel_b == !mdi_x)
        else $error("channel pairing wrong");
    a_write_resp: assert property (s_wr_take |=> s_axi_bvalid)
        else $error("no write response");
endmodule : rscl_props
bind rscl_strap_loader rscl_props u_props (.*);

// ===== tb/rscl_straps.sv
// Board strap resistors: static pulled levels on the strap pins
`timescale 1ns/100ps
module rscl_straps (
    input wire logic [10:0] level,
    output logic [10:0]     pin
);
    // Resistors only, nothing drives the pins actively during reset
    assign pin = level;
endmodule : rscl_straps

// ===== tb/tb.sv
// Testbench: strap capture, derived defaults and register-driven controls
`timescale 1ns/100ps
module tb;
    import rscl_pkg::*;
    logic        aclk = 1'b0, aresetn = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
    logic        s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic        partner_autoneg_able = 1'b1, partner_speed_100 = 1'b0, lpi_request = 1'b0;
    logic        mdix_detected = 1'b0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic        s_axi_rvalid, config_valid, managed_mode, link_power_down_en, aux_clock_enable;
    logic        an_enable, speed_100, full_duplex, polarity_correct_en, mdi_x, tx_on_channel_b;
    logic        rx_on_channel_b, ten_te_enable, lpi_allowed;
    logic [5:0]  s_axi_awaddr = 6'h00, s_axi_araddr = 6'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd_d;
    logic [3:0]  s_axi_wstrb = 4'h3;
    logic [1:0]  s_axi_bresp, s_axi_rresp, mac_iface_mode, aux_clock_freq, rd_r;
    logic [2:0]  rx_clk_delay, tx_clk_delay;
    logic [4:0]  phy_address;
    logic [10:0] lv = 11'h000;
    wire         mode_select_strap, delay_a_strap, delay_b_strap, link_c_strap, link_d_strap;
    wire         iface_e_strap, narrow_iface_select_strap, addr_bit0_strap, addr_bit1_strap;
    wire         freq_bit0_strap, freq_bit1_strap;
    int          err_total = 0, checks = 0;
    always #5 aclk = ~aclk;
    rscl_straps u_straps (.level(lv), .pin({mode_select_strap, delay_a_strap, delay_b_strap,
        link_c_strap, link_d_strap, iface_e_strap, narrow_iface_select_strap,
        addr_bit0_strap, addr_bit1_strap, freq_bit0_strap, freq_bit1_strap}));
    rscl_strap_loader DUT (.*);
    task chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task give_verdict;
        if (err_total == 0 && checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : give_verdict
    // boot changes the straps only together with reset, as the board would
    task boot(input logic [10:0] p);
        @(posedge aclk);
        lv <= p;
        aresetn <= 1'b0;
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (3) @(posedge aclk);
        #1;
    endtask : boot
    task wr(input logic [5:0] a, input logic [15:0] d);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= {16'h0, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do @(posedge aclk); while (!(s_axi_awready && s_axi_wready));
        s_axi_awvalid <= 1'b0;
        s_axi_wvalid <= 1'b0;
        do @(posedge aclk); while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
        rd_r = s_axi_bresp;
        #1;
    endtask : wr
    task rd(input logic [5:0] a);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(posedge aclk); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        do @(posedge aclk); while (!s_axi_rvalid);
        s_axi_rready <= 1'b0;
        rd_d = s_axi_rdata;
        rd_r = s_axi_rresp;
        #1;
    endtask : rd
    task t_unmanaged;
        logic [1:0] b;
        for (int i = 0; i < 4; i++) begin
            b = 2'(i);
            // Reduced interface for b 01 and 10; only 10 pairs it with a forced link pattern
            boot({1'b1, b, b, ^b, ^b, b[0], b[1], b[0], b[1]});
            chk(managed_mode, 1'b0);
            chk({rx_clk_delay, tx_clk_delay}, {b, 1'b0, b, 1'b0});
            chk(an_enable, !b[1]);
            chk(mac_iface_mode, ^b ? MACIF_RMII : MACIF_RGMII);
            chk({link_power_down_en, phy_address, aux_clock_freq}, {4'h8, b, b});
            if (b[1]) chk({speed_100, full_duplex}, {!b[0], 1'b0});
        end
    endtask : t_unmanaged
    task t_managed;
        boot(11'b0_10110_1_00_11);
        chk({managed_mode, phy_address, mac_iface_mode}, {1'b1, 5'h0d, MACIF_MII});
        chk({link_power_down_en, polarity_correct_en}, 2'b01);
        @(posedge aclk);
        lv <= 11'h7ff;
        partner_autoneg_able <= 1'b0;
        partner_speed_100 <= 1'b1;
        lpi_request <= 1'b1;
        repeat (4) @(posedge aclk);
        #1;
        chk({phy_address, speed_100, full_duplex, lpi_allowed}, {5'h0d, 3'b101});
    endtask : t_managed
    task t_regs;
        wr(OFF_BASIC_CTRL, 16'h0100);
        repeat (2) @(posedge aclk);
        #1;
        chk({an_enable, speed_100, full_duplex, lpi_allowed}, 4'b0010);
        wr(OFF_AUX_CLOCK, 16'ha000);
        rd(OFF_AUX_CLOCK);
        chk({rd_d[28:0], aux_clock_freq, aux_clock_enable}, {29'ha000, 2'b01, 1'b1});
        for (int m = 2; m < 5; m++) begin
            wr(OFF_MDI_FORCE, 16'((m & 3) << 2));
            mdix_detected <= 1'b1;
            repeat (3) @(posedge aclk);
            #1;
            chk({mdi_x, tx_on_channel_b, rx_on_channel_b}, m == 3 ? 3'b110 : 3'b001);
        end
        wr(OFF_XOVER_CTRL, 16'h0010);
        wr(OFF_TEN_TE, 16'h8000);
        chk({mdi_x, polarity_correct_en, ten_te_enable, rd_r}, {3'b101, RESP_OKAY});
        rd(6'h24);
        chk(rd_r, RESP_SLVERR);
    endtask : t_regs
    initial begin
        #200000;
        err_total++;
        give_verdict;
    end
    initial begin
        t_unmanaged;
        t_managed;
        t_regs;
        give_verdict;
    end
endmodule : tb
